// ==== sse_cfg.svh ====
/*
  Constants for the servo stop and enable input block: parameter
  codes, register offsets and timing counts.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH

// Stop-function selection codes
`define SSE_STOP_SEL_IMMEDIATE 2'h0
`define SSE_STOP_SEL_DECEL 2'h2
// Automatic-input parameter value that forces the enable on
`define SSE_AUTO_ENABLE_CODE 4'h4
// Reset values of the parameter registers
`define SSE_STOP_SEL_RST 2'h2
`define SSE_AUTO_INPUT_RST 4'h0
`define SSE_INPUT_ASSIGN_RST 8'h00
`define SSE_READY_ASSIGN_RST 8'h00
`define SSE_MODE_RST 3'h0
// Torque-limit selection is assigned when this bit of the input assignment is set
`define SSE_TL_ASSIGN_BIT 0
// Default forced-stop deceleration time in ns and derived cycles at 250 MHz
`define SSE_DECEL_TIME_NS 1000000
`define SSE_CLK_PERIOD_NS 4
`define SSE_DECEL_CYCLES (`SSE_DECEL_TIME_NS / `SSE_CLK_PERIOD_NS)
// Register offsets (byte addresses)
`define SSE_REG_STOP_SEL 8'h00
`define SSE_REG_AUTO_INPUT 8'h04
`define SSE_REG_INPUT_ASSIGN 8'h08
`define SSE_REG_READY_ASSIGN 8'h0c
`define SSE_REG_MODE 8'h10
`define SSE_REG_STATUS 8'h14
`define SSE_REG_TORQUE 8'h18

`endif

// ==== sse_pkg.sv ====
/*
  Types for the servo stop and enable input block.
  Assumes sse_cfg.svh is present in the same folder.
*/
package sse_pkg;
  `include "sse_cfg.svh"

  // Control modes, including the three switching modes
  typedef enum logic [2:0] {
    SSE_MODE_POS,
    SSE_MODE_SPD,
    SSE_MODE_TRQ,
    SSE_MODE_POS_SPD,
    SSE_MODE_SPD_TRQ,
    SSE_MODE_TRQ_POS
  } sse_mode_type;

  // Drive states
  typedef enum logic [1:0] {
    SSE_ST_OFF,
    SSE_ST_ON,
    SSE_ST_DECEL,
    SSE_ST_STOPPED
  } sse_state_type;

  // Raw discrete inputs from the connector
  typedef struct packed {
    logic servo_enable_in;
    logic forced_stop_in;
    logic ext_torque_limit_select;
    logic mode_select_in;
  } sse_pins_type;

  // Classic Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sse_wb_req_type;

  // Drive outputs
  typedef struct packed {
    logic base_on;
    logic dyn_brake;
    logic brake_interlock_out;
    logic forced_stop;
    logic decel_active;
    logic torque_from_analog;
  } sse_drive_type;
endpackage : sse_pkg

// ==== sse_sync.sv ====
/*
  Two flip-flop synchroniser, one stage pair per bit.
  Assumes inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ps
module sse_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] d_i, // Asynchronous inputs
  output logic [WIDTH-1:0] q_o // Synchronised outputs
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta[i] <= 1'b0;
          q_o[i] <= 1'b0;
        end else begin
          meta[i] <= d_i[i];
          q_o[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : sse_sync

// ==== sse_top.sv ====
/*
  Servo stop and enable input logic: servo-enable input, the two
  alternative forced-stop inputs on one shared pin, brake interlock
  timing and gating of the analog torque limit.
  // Operation
  // - Six control modes change pin meanings
  // - Unused functions need parameter assignment first
  // - Analog torque limit needs assigned selection
  // - Setting 0 makes shared pin immediate stop
  // - Immediate stop: base off, dynamic brake
  // - Setting 2 decelerates, then releases brake interlock
  // - Setting 0 releases brake interlock at once
  // - Torque mode makes decel stop immediate
  // - Enable input on energises base circuit
  // - Enable input off coasts the motor
  // - Automatic-input value 4 forces enable on
  Assumes pins are asynchronous, a classic Wishbone master on clk_i,
  and an alarm from the same clock domain.
*/
`timescale 1ns/1ps
`include "sse_cfg.svh"
module sse_top #(
  parameter int DECEL_CYCLES = `SSE_DECEL_CYCLES
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input sse_pkg::sse_pins_type pins_i, // Discrete inputs, active high = closed
  input wire logic alarm_i, // Alarm from protection logic
  input wire logic [11:0] analog_torque_limit_in_i, // Digitised analog torque limit
  input sse_pkg::sse_wb_req_type wb_i, // Wishbone request
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output sse_pkg::sse_drive_type drive_o, // Drive controls
  output logic malfunction_out_o // Alarm output, high = alarm
);
  import sse_pkg::*;

  // Elaboration check: the countdown needs at least one cycle
  if (DECEL_CYCLES < 1) begin : g_bad_decel
    $error("DECEL_CYCLES must be at least one");
  end

  localparam int CW = $clog2(DECEL_CYCLES + 1);

  // Parameter registers, drive state and countdown, synchronised pins
  logic [1:0] stop_function_select_param;
  logic [3:0] auto_input_on_param;
  logic [7:0] input_assign_param_first;
  logic [7:0] ready_output_assign_param;
  logic [2:0] mode_reg;
  sse_state_type state;
  sse_state_type next_state;
  logic [CW-1:0] decel_cnt;
  logic [CW-1:0] next_decel_cnt;
  sse_pins_type pins_s;
  logic [11:0] torque_limit_val;

  // Pins pass two flops before use; the stop line is stored inverted so the
  // flops' reset value reads as a closed stop line and no false stop follows reset
  localparam logic [3:0] PIN_IDLE = 4'h4;
  logic [3:0] pins_q;
  sse_sync #(
    .WIDTH($bits(sse_pins_type))
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_i ^ PIN_IDLE),
    .q_o(pins_q)
  );
  assign pins_s = pins_q ^ PIN_IDLE;

  // Mode decode; switching modes pick their second mode by the select pin
  wire logic [2:0] mode_w = mode_reg;
  wire logic in_torque = (mode_w == 3'(SSE_MODE_TRQ)) ||
    ((mode_w == 3'(SSE_MODE_SPD_TRQ)) && pins_s.mode_select_in) ||
    ((mode_w == 3'(SSE_MODE_TRQ_POS)) && !pins_s.mode_select_in);

  // Stop-function decode
  wire logic sel_immediate = (stop_function_select_param == `SSE_STOP_SEL_IMMEDIATE);
  wire logic sel_decel = (stop_function_select_param == `SSE_STOP_SEL_DECEL);
  // Shared pin is read as one function only
  wire logic stop_open = !pins_s.forced_stop_in;
  wire logic imm_stop_open = stop_open && sel_immediate;
  wire logic dec_stop_open = stop_open && !sel_immediate;
  // Decelerating stop in torque mode behaves as immediate
  wire logic dec_as_imm = dec_stop_open && in_torque;
  wire logic use_decel = sel_decel && !in_torque;
  wire logic hard_stop = imm_stop_open || dec_as_imm || (alarm_i && !use_decel);
  wire logic soft_stop = (dec_stop_open && !in_torque) || (alarm_i && use_decel);

  // Servo enable, forced on by the automatic-input code
  wire logic enable_eff = pins_s.servo_enable_in ||
    (auto_input_on_param == `SSE_AUTO_ENABLE_CODE);

  // Analog torque limit used only when selection is assigned and on
  wire logic tl_assigned = input_assign_param_first[`SSE_TL_ASSIGN_BIT];
  wire logic tl_use_analog = tl_assigned && pins_s.ext_torque_limit_select;

  // Next-state logic of the drive
  always_comb begin
    next_state = state;
    next_decel_cnt = decel_cnt;
    case (state)
      SSE_ST_OFF: begin
        if (hard_stop || soft_stop) begin
          next_state = SSE_ST_STOPPED;
        end else if (enable_eff) begin
          next_state = SSE_ST_ON;
        end
      end
      SSE_ST_ON: begin
        if (hard_stop) begin
          next_state = SSE_ST_STOPPED;
        end else if (soft_stop) begin
          next_state = SSE_ST_DECEL;
          next_decel_cnt = CW'(DECEL_CYCLES);
        end else if (!enable_eff) begin
          next_state = SSE_ST_OFF;
        end
      end
      SSE_ST_DECEL: begin
        if (hard_stop || decel_cnt == '0) begin
          next_state = SSE_ST_STOPPED;
        end else begin
          next_decel_cnt = decel_cnt - CW'(1);
        end
      end
      SSE_ST_STOPPED: begin
        if (!hard_stop && !soft_stop) begin
          next_state = SSE_ST_OFF;
        end
      end
      default: begin
        next_state = SSE_ST_OFF;
      end
    endcase
  end

  // Drive state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SSE_ST_OFF;
      decel_cnt <= '0;
    end else begin
      state <= next_state;
      decel_cnt <= next_decel_cnt;
    end
  end

  // Next outputs
  wire logic next_base_on = (next_state == SSE_ST_ON) || (next_state == SSE_ST_DECEL);
  wire logic next_dyn_brake = (next_state == SSE_ST_STOPPED);
  // Brake interlock held on while running or decelerating
  wire logic next_brake = next_base_on;

  // Registered drive outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
      malfunction_out_o <= 1'b0;
      torque_limit_val <= '0;
    end else begin
      drive_o.base_on <= next_base_on;
      drive_o.dyn_brake <= next_dyn_brake;
      drive_o.brake_interlock_out <= next_brake;
      drive_o.forced_stop <= next_dyn_brake;
      drive_o.decel_active <= (next_state == SSE_ST_DECEL);
      drive_o.torque_from_analog <= tl_use_analog;
      malfunction_out_o <= alarm_i;
      torque_limit_val <= tl_use_analog ? analog_torque_limit_in_i : 12'h000;
    end
  end

  // Wishbone decode
  wire logic wb_req = wb_i.cyc && wb_i.stb && !wb_ack_o;
  wire logic wb_wr = wb_req && wb_i.we && wb_i.sel[0];
  wire logic hit_stop = (wb_i.adr == `SSE_REG_STOP_SEL);
  wire logic hit_auto = (wb_i.adr == `SSE_REG_AUTO_INPUT);
  wire logic hit_inas = (wb_i.adr == `SSE_REG_INPUT_ASSIGN);
  wire logic hit_rdas = (wb_i.adr == `SSE_REG_READY_ASSIGN);
  wire logic hit_mode = (wb_i.adr == `SSE_REG_MODE);
  wire logic hit_stat = (wb_i.adr == `SSE_REG_STATUS);
  wire logic hit_trq = (wb_i.adr == `SSE_REG_TORQUE);
  // Status: state, outputs and synchronised pins
  wire logic [31:0] status_w = {20'h00000, pins_s, 2'h0, drive_o.decel_active,
    drive_o.dyn_brake, drive_o.brake_interlock_out, drive_o.base_on, 2'(state)};
  // Read mux, unmapped reads return zero
  wire logic [31:0] rd_w =
    hit_stop ? {30'h00000000, stop_function_select_param} :
    hit_auto ? {28'h0000000, auto_input_on_param} :
    hit_inas ? {24'h000000, input_assign_param_first} :
    hit_rdas ? {24'h000000, ready_output_assign_param} :
    hit_mode ? {29'h00000000, mode_reg} :
    hit_stat ? status_w :
    hit_trq ? {20'h00000, torque_limit_val} : 32'h00000000;

  // Parameter writes, selection takes effect at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_function_select_param <= `SSE_STOP_SEL_RST;
      auto_input_on_param <= `SSE_AUTO_INPUT_RST;
      input_assign_param_first <= `SSE_INPUT_ASSIGN_RST;
      ready_output_assign_param <= `SSE_READY_ASSIGN_RST;
      mode_reg <= `SSE_MODE_RST;
    end else if (wb_wr) begin
      if (hit_stop) stop_function_select_param <= wb_i.dat[1:0];
      if (hit_auto) auto_input_on_param <= wb_i.dat[3:0];
      if (hit_inas) input_assign_param_first <= wb_i.dat[7:0];
      if (hit_rdas) ready_output_assign_param <= wb_i.dat[7:0];
      if (hit_mode && wb_i.dat[2:0] <= 3'(SSE_MODE_TRQ_POS)) mode_reg <= wb_i.dat[2:0];
    end
  end

  // Acknowledge one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_w : 32'h00000000;
    end
  end
endmodule : sse_top

// ==== sse_top_properties.sv ====
/* Checker for the stop and enable block ports.
   Assumes DECEL_CYCLES of 8 or more; bound to sse_top below. */
`timescale 1ns/1ps
module sse_top_checker #(
  parameter int DECEL_CYCLES = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input sse_pkg::sse_pins_type pins_i, // Pins
  input wire logic alarm_i, // Alarm
  input wire logic [11:0] analog_torque_limit_in_i, // Analog limit
  input sse_pkg::sse_wb_req_type wb_i, // Bus request
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input sse_pkg::sse_drive_type drive_o, // Drive outputs
  input wire logic malfunction_out_o // Alarm output
);
  import sse_pkg::*;
  localparam int DMAX = DECEL_CYCLES + 4;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer and alarm copy
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_malf_follow: assert property ($rose(alarm_i) |=> malfunction_out_o) else $error("no alarm out");
  // Stop behaviour and analog torque-limit gating
  a_hard_stop: assert property (drive_o.forced_stop |-> drive_o.dyn_brake && !drive_o.base_on)
    else $error("stop keeps base");
  a_brake_base: assert property (drive_o.brake_interlock_out == drive_o.base_on)
    else $error("brake not with base");
  a_decel_hold: assert property ($rose(drive_o.decel_active) |->
    (drive_o.base_on && drive_o.brake_interlock_out)[*8]) else $error("decel cut short");
  a_decel_ends: assert property ($rose(drive_o.decel_active) |-> ##[1:DMAX] drive_o.forced_stop)
    else $error("decel not ended");
  a_stop_clear: assert property ((pins_i.forced_stop_in && !alarm_i && !drive_o.decel_active)[*6]
    |-> !drive_o.forced_stop) else $error("stop not cleared");
  a_trq_gate: assert property ((!pins_i.ext_torque_limit_select)[*6] |->
    !drive_o.torque_from_analog) else $error("analog limit ungated");
endmodule : sse_top_checker

bind sse_top sse_top_checker #(.DECEL_CYCLES(DECEL_CYCLES)) u_sse_top_checker (
  .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .alarm_i(alarm_i),
  .analog_torque_limit_in_i(analog_torque_limit_in_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .drive_o(drive_o), .malfunction_out_o(malfunction_out_o)
);

// ==== sse_host_model.sv ====
/* Host controller model driving the discrete inputs.
   Assumes the bench gives the wanted levels in pin order. */
`timescale 1ns/1ps
module sse_host_model (
  input wire logic clk_i, // Clock
  input wire logic [3:0] want_i, // Wanted levels
  output sse_pkg::sse_pins_type pins_o // Pins to the drive
);
  import sse_pkg::*;
  // Lines move just after an edge; the stop line is closed to clear a stop
  always @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule : sse_host_model

// ==== sse_top_test.sv ====
/* Self-checking bench for the stop and enable block.
   Assumes sse_top, the host model and the checker are compiled first. */
`timescale 1ns/1ps
module sse_top_test;
  import sse_pkg::*;
  logic clk_i, rst_i, alarm_i, wb_ack_o, malf;
  logic [3:0] want;
  logic [11:0] atl;
  logic [31:0] wb_dat_o;
  sse_pins_type pins;
  sse_wb_req_type wb_i;
  sse_drive_type drive_o;
  int fail_count = 0;
  int n_tests = 0;
  sse_host_model u_sse_host_model (.clk_i(clk_i), .want_i(want), .pins_o(pins));
  sse_top #(.DECEL_CYCLES(8)) u_sse_top (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
    .alarm_i(alarm_i), .analog_torque_limit_in_i(atl), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .drive_o(drive_o), .malfunction_out_o(malf));
  // Shared helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    wb_i <= {2'b11, w, 4'hf, a, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
      $display("BAD wb_ack_o exp 1 got %b", wb_ack_o);
    end
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(nm, e, q);
  endtask : rdc
  // Scenarios
  task automatic t_regs;
    cyc(3);
    chk("drive_after_reset", 32'h0, drive_o);
    rdc("stop_sel", 8'h00, 32'h2);
    rdc("auto", 8'h04, 32'h0);
    rdc("unmapped", 8'h1c, 32'h0);
    wr(8'h10, 32'h6);
    rdc("mode", 8'h10, 32'h0);
  endtask : t_regs
  task automatic t_enable;
    want <= 4'b1100;
    cyc(8);
    chk("drive_on", 32'h28, drive_o);
    want <= 4'b0100;
    cyc(8);
    chk("drive_coast", 32'h0, drive_o);
  endtask : t_enable
  task automatic stop_seq(input logic [1:0] s, input logic [2:0] md, input logic al,
    input logic [5:0] mid);
    wr(8'h00, {30'h0, s});
    wr(8'h10, {29'h0, md});
    want <= 4'b1100;
    cyc(8);
    if (al) alarm_i <= 1'b1;
    else want <= 4'b1000;
    cyc(8);
    chk("drive_mid", {26'h0, mid}, drive_o);
    chk("malfunction", {31'h0, al}, {31'h0, malf});
    cyc(14);
    chk("drive_end", 32'h14, drive_o);
    alarm_i <= 1'b0;
    want <= 4'b1100;
    cyc(8);
    chk("drive_clear", 32'h28, drive_o);
    chk("malfunction_clear", 32'h0, {31'h0, malf});
    want <= 4'b0100;
    cyc(8);
  endtask : stop_seq
  task automatic t_stops;
    stop_seq(2'h2, 3'h1, 1'b0, 6'h2a);
    stop_seq(2'h0, 3'h1, 1'b0, 6'h14);
    stop_seq(2'h2, 3'h2, 1'b0, 6'h14);
    stop_seq(2'h2, 3'h5, 1'b0, 6'h14);
    stop_seq(2'h2, 3'h0, 1'b1, 6'h2a);
    stop_seq(2'h0, 3'h4, 1'b1, 6'h14);
  endtask : t_stops
  task automatic t_auto;
    wr(8'h04, 32'h4);
    cyc(8);
    chk("drive_auto", 32'h28, drive_o);
    wr(8'h04, 32'h0);
    cyc(8);
    chk("drive_manual", 32'h0, drive_o);
  endtask : t_auto
  task automatic t_tlim;
    want <= 4'b0110;
    cyc(8);
    chk("tl_unassigned", 32'h0, drive_o);
    rdc("torque_off", 8'h18, 32'h0);
    wr(8'h08, 32'h1);
    cyc(4);
    chk("tl_on", 32'h1, drive_o);
    rdc("torque_on", 8'h18, 32'habc);
    atl <= 12'h5a3;
    cyc(2);
    rdc("torque_follow", 8'h18, 32'h5a3);
    want <= 4'b0100;
    cyc(8);
    chk("tl_off", 32'h0, drive_o);
  endtask : t_tlim
  // Verdict and end of run
  task automatic conclude;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Main sequence
  initial begin
    rst_i = 1'b1;
    alarm_i = 1'b0;
    want = 4'b0100;
    atl = 12'habc;
    wb_i = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_enable;
    t_stops;
    t_auto;
    t_tlim;
    conclude;
  end
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule : sse_top_test
